/* design/link_board_io_registers.sv */
// board-level i/o register bank decoded from processor i/o and memory cycles
// assumes one-cycle read/write strobes on clock_i; straps are asynchronous pins
// the serial port and the shared dual-port memory sit outside; only their selects and register/word numbers leave here
// watchdog expiry count comes from the package at the 250 MHz clock
`timescale 1ns/1ps
module link_board_io_registers #(
  parameter int timeout_cycles = board_io_pkg::watchdog_timeout_cycles // watchdog expiry, shorten in sim
) (
  input wire logic clock_i, // system clock, 250 MHz
  input wire logic rst_i, // synchronous power-up reset
  input wire logic [board_io_pkg::addr_width-1:0] io_addr_i, // i/o address
  input wire logic io_wr_i, // i/o write strobe, one cycle
  input wire logic io_rd_i, // i/o read strobe, one cycle
  input wire logic [7:0] io_wdata_i, // i/o write data
  input wire logic [19:0] mem_addr_i, // memory address
  input wire logic mem_cycle_i, // bus cycle in progress, one cycle
  input wire logic boot_sel_i, // boot source strap pin
  input wire logic prog_port_rate_sel_i, // programming port rate strap
  input wire logic module_style_bit0_n_i, // module style strap, low active
  input wire logic module_style_bit1_n_i, // module style strap, low active
  output logic [7:0] io_rdata_o, // read data
  output logic io_rvalid_o, // read data valid, one cycle
  output logic ready_o, // processor ready
  output logic serial_sel_o, // serial port select pulse
  output logic [2:0] serial_reg_o, // serial port register index
  output logic shared_sel_o, // shared word window select pulse
  output logic [3:0] shared_word_o, // shared word number
  output logic internal_fault_flag_o, // software internal fault
  output logic external_fault_flag_o, // software external fault
  output logic ready_suppress_n_o, // ready suppression bit
  output logic flash_prog_voltage_on_o, // programming voltage enable
  output logic [7:0] led_o, // status indicators
  output logic watchdog_fault_o, // watchdog timed out
  output logic [7:0] remote_status_report_o // status to remote controller
);
  import board_io_pkg::*;

  // address match helper used for the single-address i/o decodes
  // exact compare only; the serial window uses a range test instead
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction

  // strap synchroniser
  logic [3:0] strap_meta; // first stage, read only by strap_sync
  logic [3:0] strap_sync; // second stage
  // software-written registers
  logic [7:0] control; // board control register
  logic [7:0] next_control; // next control value
  logic [7:0] leds; // indicator register
  logic [7:0] next_leds; // next indicator value
  // next values of the registered outputs
  logic [7:0] next_rdata; // next read data
  logic next_rvalid; // next read valid pulse
  logic next_ready; // next ready pulse
  logic next_serial_sel; // next serial select
  logic [2:0] next_serial_reg; // next serial register index
  logic next_shared_sel; // next shared window select
  logic [3:0] next_shared_word; // next shared word number
  // status images
  logic [7:0] option_value; // live option register image
  logic [7:0] next_status; // next remote status byte
  // watchdog and decode helpers
  logic wd_restart; // restart pulse to watchdog
  logic wd_expired; // watchdog flag, a flop in the timer
  logic [19:0] mem_offset; // byte offset into the shared window
  logic io_cycle; // any i/o strobe this cycle

  // straps pass two flops before use
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      // clear both stages so the option image is defined during reset
      strap_meta <= 4'h0;
      strap_sync <= 4'h0;
    end
    else
    begin
      // shift the pin levels through two stages
      strap_meta <= {module_style_bit1_n_i, module_style_bit0_n_i, prog_port_rate_sel_i, boot_sel_i};
      strap_sync <= strap_meta;
    end
  end

  // option image; bit 1 reads one, upper bits zero
  always_comb
  begin
    option_value = 8'h00;
    option_value[opt_boot_sel_pos] = strap_sync[0];
    // bit 1 has no function and always reads one
    option_value[opt_bit1_pos] = 1'b1;
    option_value[opt_rate_sel_pos] = strap_sync[1];
    // style pair keeps the pin polarity: both low is single-ended
    option_value[opt_style0_pos] = strap_sync[2];
    option_value[opt_style1_pos] = strap_sync[3];
  end

  // ready and serial select answer reads and writes alike
  assign io_cycle = io_wr_i | io_rd_i;
  // wraps below the base, so the window decode also checks the lower bound
  assign mem_offset = mem_addr_i - shared_base_addr;
  // restart on any write to the port; the data is ignored
  assign wd_restart = io_wr_i & hit(io_addr_i, watchdog_restart_addr);

  // next state of registers, decodes and read path
  always_comb
  begin
    // defaults: hold registers, no selects, valid follows the read strobe, zero read data
    next_control = control;
    next_leds = leds;
    next_rdata = 8'h00;
    next_rvalid = io_rd_i;
    next_serial_sel = 1'b0;
    next_serial_reg = io_addr_i[2:0];
    next_shared_sel = 1'b0;
    next_shared_word = mem_offset[4:1];
    // board control write
    if (io_wr_i && hit(io_addr_i, board_control_addr))
    begin
      // only used positions take the write; others stay zero
      next_control = io_wdata_i & ctl_used_mask;
    end
    // indicator register write
    if (io_wr_i && hit(io_addr_i, led_status_addr))
    begin
      next_leds = io_wdata_i;
    end
    // option register read
    if (io_rd_i && hit(io_addr_i, board_option_addr))
    begin
      next_rdata = option_value;
    end
    // write-only ports and unmapped addresses read zero
    // the serial window reads zero here too; the serial port answers on its own data path
    if (io_cycle && io_addr_i >= serial_base_addr && io_addr_i <= serial_last_addr)
    begin
      next_serial_sel = 1'b1;
    end
    // 16-bit words: byte offset 2n selects word n
    if (mem_cycle_i && mem_addr_i >= shared_base_addr && mem_offset < 20'(2 * shared_words))
    begin
      next_shared_sel = 1'b1;
    end
    // ready on every i/o or memory cycle unless suppressed
    next_ready = ~control[ctl_ready_suppress_pos] & (io_cycle | mem_cycle_i);
    // remote status: option bits with bit 5 held clear, watchdog in the bit 7 slot
    // bit 7 of the option image is always zero, so it is free to carry the fault
    next_status = {option_value[7:6], 1'b0, option_value[4:0]};
    next_status[7] = wd_expired;
  end

  // register everything
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      // power-up values; ready suppression starts cleared
      control <= ctl_reset_value;
      leds <= led_reset_value;
      io_rdata_o <= 8'h00;
      io_rvalid_o <= 1'b0;
      ready_o <= 1'b0;
      serial_sel_o <= 1'b0;
      serial_reg_o <= 3'h0;
      shared_sel_o <= 1'b0;
      shared_word_o <= 4'h0;
      remote_status_report_o <= 8'h00;
    end
    else
    begin
      // load next values
      control <= next_control;
      leds <= next_leds;
      io_rdata_o <= next_rdata;
      io_rvalid_o <= next_rvalid;
      ready_o <= next_ready;
      serial_sel_o <= next_serial_sel;
      serial_reg_o <= next_serial_reg;
      shared_sel_o <= next_shared_sel;
      shared_word_o <= next_shared_word;
      remote_status_report_o <= next_status;
    end
  end

  // fault flags are control bits, already flop outputs
  assign internal_fault_flag_o = control[ctl_internal_fault_pos];
  assign external_fault_flag_o = control[ctl_external_fault_pos];
  // low keeps the automatic ready on
  assign ready_suppress_n_o = control[ctl_ready_suppress_pos];
  // programming voltage switch
  assign flash_prog_voltage_on_o = control[ctl_prog_voltage_pos];
  // indicator k+1 lights when bit k is one
  assign led_o = leds;
  // sticky: only a power-up reset clears a watchdog fault
  assign watchdog_fault_o = wd_expired;

  // watchdog counter; its flag is a flop output
  // the parameter lets a bench shorten the 160 ms expiry
  watchdog_timer #(
    .timeout_cycles(timeout_cycles),
    .count_width(watchdog_count_width)
  ) i_watchdog_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .restart_i(wd_restart),
    .expired_o(wd_expired)
  );
endmodule

/* design/board_io_pkg.sv */
// board i/o register set constants: i/o addresses, field positions, timing
// assumes a 250 MHz system clock and byte-wide processor i/o cycles
package board_io_pkg;
  localparam int addr_width = 16;
  localparam logic [15:0] serial_base_addr = 16'h03f8;
  localparam logic [15:0] serial_last_addr = 16'h03ff;
  localparam logic [15:0] watchdog_restart_addr = 16'h0900;
  localparam logic [15:0] led_status_addr = 16'h0980;
  localparam logic [15:0] board_option_addr = 16'h0a00;
  localparam logic [15:0] board_control_addr = 16'h0a80;
  // shared controller word window base (memory space, 20-bit physical)
  localparam logic [19:0] shared_base_addr = 20'ha0000;
  localparam int shared_words = 16;
  // board control field positions
  localparam int ctl_internal_fault_pos = 0;
  localparam int ctl_external_fault_pos = 1;
  localparam int ctl_ready_suppress_pos = 4;
  localparam int ctl_prog_voltage_pos = 7;
  localparam logic [7:0] ctl_reset_value = 8'h00;
  localparam logic [7:0] ctl_used_mask = 8'h93;
  // board option field positions
  localparam int opt_boot_sel_pos = 0;
  localparam int opt_bit1_pos = 1;
  localparam int opt_rate_sel_pos = 2;
  localparam int opt_style0_pos = 3;
  localparam int opt_style1_pos = 4;
  localparam logic [7:0] led_reset_value = 8'h00;
  // watchdog timeout
  localparam int clock_mhz = 250;
  localparam int watchdog_timeout_ms = 160;
  localparam int watchdog_timeout_cycles = watchdog_timeout_ms * 1000 * clock_mhz;
  localparam int watchdog_count_width = 26;
endpackage

/* design/watchdog_timer.sv */
// watchdog counter restarted by a one-cycle pulse
// assumes restart pulse is synchronous to clock_i
`timescale 1ns/1ps
module watchdog_timer #(
  parameter int timeout_cycles = board_io_pkg::watchdog_timeout_cycles, // cycles to expiry
  parameter int count_width = board_io_pkg::watchdog_count_width // counter width
) (
  input wire logic clock_i, // system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic restart_i, // one-cycle restart pulse
  output logic expired_o // sticky timeout flag
);
  import board_io_pkg::*;
  localparam logic [count_width-1:0] last_count = count_width'(timeout_cycles - 1);
  logic [count_width-1:0] count; // cycles since last restart
  logic [count_width-1:0] next_count;
  logic next_expired;
  // count up; a restart always wins, expiry stays until power-up reset
  always_comb
  begin
    next_count = count;
    next_expired = expired_o;
    if (restart_i)
    begin
      next_count = '0;
    end
    else if (count == last_count)
    begin
      next_expired = 1'b1;
    end
    else
    begin
      next_count = count + 1'b1;
    end
  end
  // register state
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      count <= '0;
      expired_o <= 1'b0;
    end
    else
    begin
      count <= next_count;
      expired_o <= next_expired;
    end
  end
endmodule

/* tb/board_io_monitor.sv */
// port assertions for the board i/o register bank
// assumes a bind onto the top module; one clock, sync reset
`timescale 1ns/1ps
module board_io_monitor (
  input wire logic clock_i, // clock
  input wire logic rst_i, // reset
  input wire logic [board_io_pkg::addr_width-1:0] io_addr_i, // address
  input wire logic io_wr_i, // write
  input wire logic io_rd_i, // read
  input wire logic [7:0] io_wdata_i, // write data
  input wire logic mem_cycle_i, // memory cycle
  input wire logic [7:0] io_rdata_o, // read data
  input wire logic io_rvalid_o, // read valid
  input wire logic ready_o, // ready
  input wire logic serial_sel_o, // serial select
  input wire logic [2:0] serial_reg_o, // serial index
  input wire logic internal_fault_flag_o, // flag
  input wire logic external_fault_flag_o, // flag
  input wire logic ready_suppress_n_o, // suppress
  input wire logic flash_prog_voltage_on_o // vpp
);
  import board_io_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic ctl_wr; // control write, which may change ready itself
  assign ctl_wr = io_wr_i && io_addr_i == board_control_addr;
  a_option_upper_zero: assert property (io_rd_i && io_addr_i == board_option_addr |=> io_rvalid_o && io_rdata_o[7:5] == 3'h0)
    else $error("option upper bits set");
  a_internal_flag_load: assert property (ctl_wr |=> internal_fault_flag_o == $past(io_wdata_i[0]))
    else $error("internal flag wrong");
  a_external_flag_load: assert property (ctl_wr |=> external_fault_flag_o == $past(io_wdata_i[1]))
    else $error("external flag wrong");
  a_ready_each_cycle: assert property ((io_wr_i || io_rd_i || mem_cycle_i) && !ctl_wr && !ready_suppress_n_o |=> ready_o)
    else $error("ready missing");
  a_ready_withheld: assert property (ready_suppress_n_o && !ctl_wr |=> !ready_o)
    else $error("ready while suppressed");
  a_suppress_reset_clear: assert property ($fell(rst_i) |-> !ready_suppress_n_o)
    else $error("suppress set after reset");
  a_prog_voltage_load: assert property (ctl_wr |=> flash_prog_voltage_on_o == $past(io_wdata_i[7]))
    else $error("vpp wrong");
  a_serial_decode: assert property ((io_wr_i || io_rd_i) && io_addr_i[15:3] == serial_base_addr[15:3]
    |=> serial_sel_o && serial_reg_o == $past(io_addr_i[2:0]))
    else $error("serial decode wrong");
  c_suppress: cover property (ctl_wr ##1 ready_suppress_n_o);
  c_serial: cover property (serial_sel_o);
  c_read: cover property (io_rvalid_o);
endmodule

/* tb/cpu_bus_model.sv */
// processor bus model: byte i/o and memory cycles, one strobe cycle each
// assumes the block answers one cycle after the strobe edge
`timescale 1ns/1ps
module cpu_bus_model (
  input wire logic clock_i, // clock
  output logic [15:0] io_addr_o, // address
  output logic io_wr_o, // write
  output logic io_rd_o, // read
  output logic [7:0] io_wdata_o, // data
  output logic [19:0] mem_addr_o, // memory address
  output logic mem_cycle_o // memory cycle
);
  initial
  begin
    {io_addr_o, io_wr_o, io_rd_o, io_wdata_o, mem_addr_o, mem_cycle_o} = '0;
  end
  // released lines show the inverse so stale values never match by luck
  task io(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_i);
    io_addr_o <= a;
    io_wdata_o <= d;
    io_wr_o <= w;
    io_rd_o <= !w;
    @(posedge clock_i);
    {io_wr_o, io_rd_o} <= 2'h0;
    io_addr_o <= ~a;
    io_wdata_o <= ~d;
    #1;
  endtask
  task mem(input logic [19:0] a);
    @(posedge clock_i);
    mem_addr_o <= a;
    mem_cycle_o <= 1'b1;
    @(posedge clock_i);
    mem_cycle_o <= 1'b0;
    mem_addr_o <= ~a;
    #1;
  endtask
endmodule

/* tb/link_board_io_registers_test.sv */
// self-checking bench for the board i/o register bank
// assumes a shortened watchdog of tmo cycles
`timescale 1ns/1ps
module link_board_io_registers_test;
  import board_io_pkg::*;
  localparam int tmo = 100; // watchdog expiry in sim
  logic clock_i, rst_i, io_wr, io_rd, mem_cycle, io_rvalid, ready, serial_sel, shared_sel;
  logic int_f, ext_f, supp, vpp, wd_fault;
  logic [15:0] io_addr;
  logic [19:0] mem_addr;
  logic [7:0] io_wdata, io_rdata, led, remote, opt;
  logic [3:0] straps; // style1_n, style0_n, rate, boot
  logic [2:0] serial_reg;
  logic [3:0] shared_word;
  int err_count = 0, checked = 0, cycles = 0;
  cpu_bus_model m (.clock_i(clock_i), .io_addr_o(io_addr), .io_wr_o(io_wr), .io_rd_o(io_rd),
    .io_wdata_o(io_wdata), .mem_addr_o(mem_addr), .mem_cycle_o(mem_cycle));
  link_board_io_registers #(.timeout_cycles(tmo)) i_link_board_io_registers (.clock_i(clock_i),
    .rst_i(rst_i), .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata),
    .mem_addr_i(mem_addr), .mem_cycle_i(mem_cycle), .boot_sel_i(straps[0]), .prog_port_rate_sel_i(straps[1]),
    .module_style_bit0_n_i(straps[2]), .module_style_bit1_n_i(straps[3]), .io_rdata_o(io_rdata),
    .io_rvalid_o(io_rvalid), .ready_o(ready), .serial_sel_o(serial_sel), .serial_reg_o(serial_reg),
    .shared_sel_o(shared_sel), .shared_word_o(shared_word), .internal_fault_flag_o(int_f),
    .external_fault_flag_o(ext_f), .ready_suppress_n_o(supp), .flash_prog_voltage_on_o(vpp),
    .led_o(led), .watchdog_fault_o(wd_fault), .remote_status_report_o(remote));
  task chk(input string n, input logic [19:0] e, input logic [19:0] s);
    checked++;
    if (s !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask
  task give_verdict;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // restarts with any data hold off expiry; silence then trips it
  task t_watchdog;
    for (int i = 0; i < 3; i++)
    begin
      m.io(1'b1, watchdog_restart_addr, i[0] ? 8'hff : 8'h00);
      repeat (tmo - 20) @(posedge clock_i);
      #1;
      chk("wd", 1'b0, wd_fault);
    end
    // tmo - 1 edges after the last restart still quiet, the next edge expires
    repeat (19) @(posedge clock_i);
    #1;
    chk("wd", 1'b0, wd_fault);
    @(posedge clock_i);
    #1;
    chk("wd", 1'b1, wd_fault);
  endtask
  task t_option;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clock_i);
      straps <= i[0] ? 4'h5 : 4'ha;
      repeat (3) @(posedge clock_i);
      opt = {3'h0, straps[3:1], 1'b1, straps[0]};
      m.io(1'b0, board_option_addr, 8'h00);
      chk("opt", {1'b1, opt}, {io_rvalid, io_rdata});
      chk("remote", {1'b1, opt[6:0]}, remote);
    end
  endtask
  task t_control;
    m.io(1'b1, board_control_addr, 8'hff);
    chk("ctl", 4'hf, {vpp, supp, ext_f, int_f});
    m.io(1'b0, board_option_addr, 8'h00);
    chk("ready", 1'b0, ready);
    m.io(1'b1, board_control_addr, 8'h6c);
    chk("ctl", 4'h0, {vpp, supp, ext_f, int_f});
    m.io(1'b0, board_control_addr, 8'h00);
    chk("ready", 9'h100, {ready, io_rdata});
    m.io(1'b1, board_control_addr, 8'h81);
    chk("ctl", 4'h9, {vpp, supp, ext_f, int_f});
    m.io(1'b1, board_control_addr, 8'h02);
    chk("ctl", 4'h2, {vpp, supp, ext_f, int_f});
  endtask
  task t_decode;
    for (int a = 16'h03f7; a <= 16'h0400; a++)
    begin
      m.io(a[0], a[15:0], 8'h00);
      chk("ser", a >= 16'h03f8 && a <= 16'h03ff, serial_sel);
      if (a >= 16'h03f8 && a <= 16'h03ff)
        chk("reg", a[2:0], serial_reg);
    end
    for (int n = 0; n <= 16; n++)
    begin
      m.mem(shared_base_addr + 20'(2 * n));
      chk("shared", {n < 16, n[3:0]}, {shared_sel, n < 16 ? shared_word : 4'h0});
    end
    m.io(1'b1, led_status_addr, 8'ha5);
    chk("led", 8'ha5, led);
  endtask
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      err_count++;
      give_verdict;
    end
  end
  initial
  begin
    rst_i = 1'b1;
    straps = 4'h0;
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    chk("reset", 12'h0, {vpp, supp, ext_f, int_f, led});
    t_watchdog;
    t_option;
    t_control;
    t_decode;
    give_verdict;
  end
endmodule
bind link_board_io_registers board_io_monitor i_mon (.clock_i(clock_i), .rst_i(rst_i), .io_addr_i(io_addr_i),
  .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .mem_cycle_i(mem_cycle_i),
  .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o), .ready_o(ready_o), .serial_sel_o(serial_sel_o),
  .serial_reg_o(serial_reg_o), .internal_fault_flag_o(internal_fault_flag_o),
  .external_fault_flag_o(external_fault_flag_o), .ready_suppress_n_o(ready_suppress_n_o),
  .flash_prog_voltage_on_o(flash_prog_voltage_on_o));
